// ### common/timer_dma_burst_defs.vh
`ifndef TIMER_DMA_BURST_DEFS_VH
`define TIMER_DMA_BURST_DEFS_VH

// Register byte offsets on the register bus
`define OFF_CONTROL 8'h48
`define OFF_WINDOW 8'h4C
`define OFF_MODE 8'h50
`define OFF_STATUS 8'h54

// Byte address of the first timer control register
`define FIRST_CONTROL_ADDR 8'h00

// Control register field positions
`define BASE_LSB 0
`define BASE_MSB 4
`define LEN_LSB 8
`define LEN_MSB 12

// Reset values
`define CONTROL_RESET 16'h0000
`define WINDOW_RESET 16'h0000

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### sim/burst_window_chk.sv
`timescale 1ns/1ps
// Port checks of the burst window
module burst_window_chk (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Register bus handshakes
	input wire awvalid,
	input wire awready,
	input wire arvalid,
	input wire arready,
	input wire bvalid,
	input wire bready,
	input wire rvalid,
	input wire rready,
	// Register bus responses
	input wire [1:0] bresp,
	input wire [1:0] rresp,
	input wire [31:0] rdata,
	// Timer register port
	input wire tgt_valid,
	input wire tgt_ready,
	input wire tgt_write,
	input wire [7:0] tgt_addr,
	input wire [15:0] tgt_wdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Target request waiting for the register file
	sequence tgt_stall;
		tgt_valid && !tgt_ready;
	endsequence
	a_tgt_hold: assert property (tgt_stall |=> tgt_valid && $stable({tgt_write, tgt_addr, tgt_wdata}))
		else $error("target request moved while stalled");
	a_tgt_align: assert property (tgt_valid |-> tgt_addr[1:0] == 2'b00)
		else $error("target address not on a register");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
		else $error("read response dropped");
	a_aw_once: assert property (awvalid && awready |=> !awready)
		else $error("second write address taken");
	a_ar_once: assert property (arvalid && arready |=> !arready)
		else $error("second read address taken");
	a_err_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0000_0000)
		else $error("error read carries data");
	a_reset_quiet: assert property ($rose(nrst) |-> !bvalid && !rvalid && !tgt_valid)
		else $error("activity right after reset");
endmodule

bind timer_dma_burst_window burst_window_chk chk (.clock, .nrst, .awvalid, .awready, .arvalid,
	.arready, .bvalid, .bready, .rvalid, .rready, .tgt_valid, .tgt_ready, .tgt_write, .bresp,
	.rresp, .rdata, .tgt_addr, .tgt_wdata);

// ### sim/timer_dma_burst_window_test.sv
`timescale 1ns/1ps
module timer_dma_burst_window_test;
	reg clock = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg stall = 0, ready_en = 0, slow = 0;
	reg [3:0] strb = 4'hf; // Byte lanes of writes
	reg [7:0] awaddr = 0, araddr = 0;
	reg [31:0] wdata = 0, got;
	reg [1:0] rsp;
	wire awready, wready, bvalid, arready, rvalid, tgt_valid, tgt_ready, tgt_write;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] tgt_addr;
	wire [15:0] tgt_wdata, tgt_rdata;
	integer fail_count = 0, checks = 0, seed = 33797, i, k, base, len, mode, idx;
	integer exp_mem [0:63]; // Expected register file
	timer_dma_burst_window uut (.clock, .nrst, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb(strb), .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .tgt_valid, .tgt_ready,
		.tgt_write, .tgt_addr, .tgt_wdata, .tgt_rdata);
	timer_regs_model pm (.clock, .ready_en, .tgt_valid, .tgt_write, .tgt_addr, .tgt_wdata,
		.tgt_ready, .tgt_rdata);
	initial forever #4 clock = ~clock;
	// Random target pacing, held off while stalling
	always @(posedge clock) ready_en <= stall ? 1'b0 : (($random(seed) & 1) != 0);
	initial
	begin
		#500000 fail_count = fail_count + 1;
		report_and_stop;
	end
	task chk(input [31:0] g, input [31:0] e);
		checks = checks + 1;
		if (g !== e)
		begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Bus response codes
	task chk_resp(input [1:0] g, input [1:0] e);
		chk({30'h0000_0000, g}, {30'h0000_0000, e});
	endtask
	// Timer register contents
	task chk_mem(input [15:0] g, input integer e);
		chk({16'h0000, g}, e);
	endtask
	task report_and_stop;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clock);
		awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d; bready <= !slow;
		do
		begin
			@(posedge clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid && !bready) bready <= 1;
		end while (!(bvalid && bready));
		rsp = bresp; bready <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge clock);
		arvalid <= 1; araddr <= a; rready <= !slow;
		do
		begin
			@(posedge clock);
			if (arready) arvalid <= 0;
			if (rvalid && !rready) rready <= 1;
		end while (!(rvalid && rready));
		got = rdata; rsp = rresp; rready <= 0;
	endtask
	task adv;
		idx = (idx == len) ? 0 : idx + 1;
	endtask
	// Control write with reserved bits set, then read back
	task ctl(input integer b, input integer l);
		base = b; len = l; idx = 0;
		wr(8'h48, 32'hffff_e0e0 | (l << 8) | b);
		rd(8'h48);
		chk(got, l * 256 + b);
	endtask
	task win_w(input [15:0] d);
		wr(8'h4c, d);
		chk_resp(rsp, 2'h0);
		if (mode)
		begin
			exp_mem[base + idx] = d[15:8]; adv;
			exp_mem[base + idx] = d[7:0]; adv;
		end
		else
		begin
			exp_mem[base + idx] = d; adv;
		end
	endtask
	task win_r;
		integer e;
		rd(8'h4c);
		e = (exp_mem[base + idx] & 255) * (mode ? 256 : 0) + (mode ? 0 : exp_mem[base + idx]);
		adv;
		if (mode)
		begin
			e = e + (exp_mem[base + idx] & 255); adv;
		end
		chk(got, e);
	endtask
	task memchk;
		for (i = 0; i < 64; i = i + 1) chk_mem(pm.mem[i], exp_mem[i]);
	endtask
	initial
	begin
		for (i = 0; i < 64; i = i + 1) exp_mem[i] = 0;
		mode = 0; idx = 0; base = 0; len = 0;
		repeat (6) @(posedge clock);
		nrst <= 1;
		rd(8'h48); chk(got, 0);
		rd(8'h4c); chk(got, 0);
		rd(8'h60);
		chk_resp(rsp, 2'h2);
		chk(got, 0);
		// Lane zero alone reaches the base field only
		ctl(3, 5);
		strb <= 4'h1;
		wr(8'h48, 32'h0000_1f09);
		strb <= 4'hf;
		rd(8'h48);
		chk(got, 32'h0000_0509);
		// Bursts in both modes, lengths one, eighteen and random
		for (k = 0; k < 6; k = k + 1)
		begin
			mode = k % 2;
			// Late response ready in the last bursts
			slow = (k > 3);
			wr(8'h50, mode);
			ctl($random(seed) & 15, (k == 0) ? 0 : (k == 2) ? 17 : (($random(seed) & 7) * 2 + 1));
			for (i = 0; i <= len + 1; i = i + 1) win_w($random(seed));
			rd(8'h54); chk(got, idx);
			ctl(base, len);
			for (i = 0; i <= len; i = i + 1) win_r;
			memchk;
		end
		// Fill the buffer with the target stalled, then release
		mode = 0; wr(8'h50, 0); ctl(2, 7);
		stall <= 1;
		for (k = 0; k < 4; k = k + 1) win_w($random(seed));
		fork
			win_w(16'hbeef);
			begin
				repeat (30) @(posedge clock);
				chk({bvalid, tgt_valid}, 2'b01);
				stall <= 0;
			end
		join
		win_r;
		memchk;
		report_and_stop;
	end
endmodule

// ### sim/timer_regs_model.sv
`timescale 1ns/1ps
// Timer register file behind the window
module timer_regs_model (
	// Clock and pacing
	input wire clock,
	input wire ready_en,
	// Target port
	input wire tgt_valid,
	input wire tgt_write,
	input wire [7:0] tgt_addr,
	input wire [15:0] tgt_wdata,
	output wire tgt_ready,
	output wire [15:0] tgt_rdata
);
	reg [15:0] mem [0:63]; // Register contents
	reg [15:0] junk = 16'h5a5a; // Moving filler
	integer i;
	initial for (i = 0; i < 64; i = i + 1) mem[i] = 16'h0000;
	assign tgt_ready = tgt_valid && ready_en;
	// Data only during a taken read
	assign tgt_rdata = (tgt_ready && !tgt_write) ? mem[tgt_addr[7:2]] : junk;
	// One register per taken write
	always @(posedge clock)
	begin
		junk <= ~junk + 16'h0001;
		if (tgt_ready && tgt_write)
			mem[tgt_addr[7:2]] <= tgt_wdata;
	end
endmodule

// ### verilog/burst_fifo.v
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module burst_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
	reg [AW-1:0] wr_ptr; // Write pointer
	reg [AW-1:0] rd_ptr; // Read pointer
	reg [AW:0] count; // Fill level
	wire push; // Entry accepted
	wire pop; // Entry drained

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and level bookkeeping
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	// Storage write, no reset needed
	always @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// ### verilog/timer_dma_burst_window.v
// Behaviour
// [RULE1] Five-bit base offset in control bits 4:0
// [RULE2] Base counts registers from first control register
// [RULE3] Length field bits 12:8 gives N+1 transfers
// [RULE4] Window access hits first control plus 4*(base+index)
// [RULE5] Index advances per transfer, hardware owned
// [RULE6] Word mode: one register per transfer
// [RULE7] Byte mode: high part first, low second
// [RULE8] Window and control reset to zero
// [RULE9] Reserved control bits read zero, ignore writes
// [RULE10] Index restarts at zero, wraps after last
`timescale 1ns/1ps
`include "timer_dma_burst_defs.vh"

module timer_dma_burst_window #(
	parameter ADDR_W = 8,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
) (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Write address channel
	input wire awvalid,
	output wire awready,
	input wire [ADDR_W-1:0] awaddr,
	input wire [2:0] awprot,
	// Write data channel
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// Write response channel
	output wire bvalid,
	input wire bready,
	output reg [1:0] bresp,
	// Read address channel
	input wire arvalid,
	output wire arready,
	input wire [ADDR_W-1:0] araddr,
	input wire [2:0] arprot,
	// Read data channel
	output wire rvalid,
	input wire rready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	// Timer register port
	output wire tgt_valid,
	input wire tgt_ready,
	output wire tgt_write,
	output wire [7:0] tgt_addr,
	output wire [15:0] tgt_wdata,
	input wire [15:0] tgt_rdata
);
	// Engine states
	localparam IDLE = 3'd0;
	localparam WPUSH = 3'd1;
	localparam WPUSH2 = 3'd2;
	localparam BRESP = 3'd3;
	localparam RWAIT = 3'd4;
	localparam RREAD = 3'd5;
	localparam RREAD2 = 3'd6;
	localparam RRESP = 3'd7;

	// Control reset value, sliced per field
	localparam [15:0] CONTROL_INIT = `CONTROL_RESET;

	reg [2:0] state; // Engine state
	reg aw_held; // Write address captured
	reg w_held; // Write data captured
	reg [ADDR_W-1:0] aw_addr; // Captured write address
	reg [31:0] w_data; // Captured write data
	reg [3:0] w_strb; // Captured byte lanes
	reg [4:0] base; // Burst base offset
	reg [4:0] len; // Burst length minus one
	reg byte_mode; // Eight-bit data mode
	reg [4:0] idx; // Running burst index
	reg [15:0] rd_hold; // Assembled window read data
	reg [7:0] rd_addr; // Address of current target read
	wire [4:0] next_idx; // Index after one transfer
	wire [5:0] reg_step; // Register step from first control
	wire [7:0] cur_addr; // Byte address of current register
	wire reading; // Target read in progress
	wire fifo_in_valid; // Push request
	wire fifo_in_ready; // FIFO has room
	wire [23:0] fifo_in_data; // Address and data to push
	wire fifo_out_valid; // FIFO holds a write
	wire [23:0] fifo_out_data; // Head entry
	wire [15:0] push_data; // Data of current push
	wire wr_go; // Both write halves present
	wire ar_go; // Read address accepted
	wire [31:0] ctrl_word; // Control register readback

	// Index wraps after the last programmed transfer
	assign next_idx = (idx == len) ? 5'd0 : idx + 5'd1; // [RULE5] [RULE10] [RULE3]

	// Register step is base plus index
	assign reg_step = {1'b0, base} + {1'b0, idx}; // [RULE2]

	// Redirected byte address
	assign cur_addr = `FIRST_CONTROL_ADDR + {reg_step, 2'b00}; // [RULE4]

	// Control word with reserved bits forced low
	assign ctrl_word = {16'h0000, 3'b000, len, 3'b000, base}; // [RULE9]

	// Channel handshakes
	assign awready = !aw_held;
	assign wready = !w_held;
	assign wr_go = aw_held && w_held && (state == IDLE);
	assign arready = (state == IDLE) && !(aw_held && w_held);
	assign ar_go = arvalid && arready;
	assign bvalid = (state == BRESP);
	assign rvalid = (state == RRESP);

	// Byte mode splits the item, high part first
	assign push_data = !byte_mode ? w_data[15:0] : // [RULE6]
		(state == WPUSH) ? {8'h00, w_data[15:8]} : {8'h00, w_data[7:0]}; // [RULE7]

	// Writes queue through the FIFO
	assign fifo_in_valid = (state == WPUSH) || (state == WPUSH2);
	assign fifo_in_data = {cur_addr, push_data};

	// Target port is shared by drained writes and direct reads
	assign reading = (state == RREAD) || (state == RREAD2);
	assign tgt_valid = reading ? 1'b1 : fifo_out_valid;
	assign tgt_write = !reading;
	assign tgt_addr = reading ? rd_addr : fifo_out_data[23:16];
	assign tgt_wdata = fifo_out_data[15:0];

	// Write buffer between window and timer registers
	burst_fifo #(
		.WIDTH(24),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) write_queue (
		.clock(clock),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(!reading && tgt_ready),
		.out_data(fifo_out_data)
	);

	// Capture write address and data in either order
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {ADDR_W{1'b0}};
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else
		begin
			// Address half
			if (awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			else if (bvalid && bready)
				aw_held <= 1'b0;
			// Data half
			if (wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			else if (bvalid && bready)
				w_held <= 1'b0;
		end
	end

	// Main engine: register access and burst sequencing
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			state <= IDLE;
			base <= CONTROL_INIT[`BASE_MSB:`BASE_LSB]; // [RULE8]
			len <= CONTROL_INIT[`LEN_MSB:`LEN_LSB]; // [RULE8]
			byte_mode <= 1'b0;
			idx <= 5'd0;
			rd_hold <= `WINDOW_RESET; // [RULE8]
			rd_addr <= 8'h00;
			bresp <= `RESP_OKAY;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end
		else
		begin
			case (state)
				IDLE:
				begin
					if (wr_go)
					begin
						bresp <= `RESP_OKAY;
						// Address decode for writes
						if (aw_addr == `OFF_WINDOW)
							state <= WPUSH;
						else if (aw_addr == `OFF_CONTROL)
						begin
							// Reserved bits are not stored
							if (w_strb[0])
								base <= w_data[`BASE_MSB:`BASE_LSB]; // [RULE1] [RULE9]
							if (w_strb[1])
								len <= w_data[`LEN_MSB:`LEN_LSB]; // [RULE3] [RULE9]
							// New programming starts a new burst
							idx <= 5'd0; // [RULE10]
							state <= BRESP;
						end
						else if (aw_addr == `OFF_MODE)
						begin
							if (w_strb[0])
								byte_mode <= w_data[0];
							state <= BRESP;
						end
						else if (aw_addr == `OFF_STATUS)
							state <= BRESP;
						else
						begin
							// Unmapped address
							bresp <= `RESP_SLVERR;
							state <= BRESP;
						end
					end
					else if (ar_go)
					begin
						rresp <= `RESP_OKAY;
						rdata <= 32'h0000_0000;
						// Address decode for reads
						if (araddr == `OFF_WINDOW)
							state <= RWAIT;
						else if (araddr == `OFF_CONTROL)
						begin
							rdata <= ctrl_word;
							state <= RRESP;
						end
						else if (araddr == `OFF_MODE)
						begin
							rdata <= {31'h0000_0000, byte_mode};
							state <= RRESP;
						end
						else if (araddr == `OFF_STATUS)
						begin
							rdata <= {27'h000_0000, idx};
							state <= RRESP;
						end
						else
						begin
							// Unmapped address
							rresp <= `RESP_SLVERR;
							state <= RRESP;
						end
					end
				end
				WPUSH:
				begin
					// First part of the item enters the queue
					if (fifo_in_ready)
					begin
						idx <= next_idx; // [RULE5]
						state <= byte_mode ? WPUSH2 : BRESP; // [RULE6] [RULE7]
					end
				end
				WPUSH2:
				begin
					// Low byte to the following register
					if (fifo_in_ready)
					begin
						idx <= next_idx; // [RULE7]
						state <= BRESP;
					end
				end
				BRESP:
				begin
					// Hold response until taken
					if (bready)
						state <= IDLE;
				end
				RWAIT:
				begin
					// Queued writes land before any read
					if (!fifo_out_valid)
					begin
						rd_addr <= cur_addr; // [RULE4]
						state <= RREAD;
					end
				end
				RREAD:
				begin
					// First register read
					if (tgt_ready)
					begin
						if (byte_mode)
							rd_hold <= {tgt_rdata[7:0], 8'h00}; // [RULE7]
						else
							rd_hold <= tgt_rdata; // [RULE6]
						idx <= next_idx; // [RULE5]
						if (byte_mode)
						begin
							rd_addr <= `FIRST_CONTROL_ADDR + {({1'b0, base} + {1'b0, next_idx}), 2'b00};
							state <= RREAD2;
						end
						else
						begin
							rdata <= {16'h0000, tgt_rdata};
							state <= RRESP;
						end
					end
				end
				RREAD2:
				begin
					// Second register gives the low byte
					if (tgt_ready)
					begin
						rd_hold <= {rd_hold[15:8], tgt_rdata[7:0]};
						rdata <= {16'h0000, rd_hold[15:8], tgt_rdata[7:0]}; // [RULE7]
						idx <= next_idx; // [RULE5]
						state <= RRESP;
					end
				end
				RRESP:
				begin
					// Hold read data until taken
					if (rready)
						state <= IDLE;
				end
				default:
				begin
					state <= IDLE;
				end
			endcase
		end
	end
endmodule
